// ===== logic/tkh_pkg.sv
// Package for the host-side controller of a byte-wide clock/calendar SRAM.
// Assumes a 10 MHz pclk and an APB master reaching the controller registers.
package tkh_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int T_ACCESS_NS = 70;
  localparam int T_WPULSE_NS = 60;
  localparam int T_CYCLE_NS = 70;
  localparam int SYNC_STAGES = 2;

  // Least time in ns rounded up to whole cycles, never below one
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ACCESS_CYC = ns_to_cycles(T_ACCESS_NS);
  localparam int WPULSE_CYC = ns_to_cycles(T_WPULSE_NS);
  localparam int RECOVER_CYC = ns_to_cycles(T_CYCLE_NS);

  // ----------------------------------------------------------------
  // Device memory map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam logic [12:0] CLOCK_BASE = 13'h1FF8;
  localparam logic [12:0] CLOCK_CTRL_ADDR = 13'h1FF8;
  localparam int CTRL_FREEZE_BIT = 6;
  localparam int CTRL_LOAD_BIT = 7;

  // ----------------------------------------------------------------
  // Controller registers (APB byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_ERR_BIT = 2;
  localparam int ST_PFAIL_BIT = 3;
  localparam int ST_CLOCK_BIT = 4;

  // Pins driven toward the device
  typedef struct packed {
    logic [12:0] addr;
    logic chip_sel_n;
    logic out_drive_n;
    logic write_n;
    logic [7:0] data_out;
    logic data_oe;
  } tkh_pins_t;

  localparam tkh_pins_t PINS_IDLE = '{addr: 13'h0000, chip_sel_n: 1'b1,
    out_drive_n: 1'b1, write_n: 1'b1, data_out: 8'h00, data_oe: 1'b0};

endpackage

// ===== logic/tkh_host.sv
// Host controller that drives a byte-wide clock/calendar SRAM over its pins.
// Assumes an APB master on pclk and an asynchronous device on the pins.
// Summary of operation
// - Host holds the address stable across the whole write cycle.
// - Host returns select or strobe high for the recovery interval.
// - Host drives write data before the end edge and holds it after.
// - Host keeps output drive high during write cycles.
//
// Register access over APB was decided locally.

`timescale 1ns/1ps
`default_nettype none

module tkh_host
  import tkh_pkg::*;
#(
  parameter int CNT_W = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output tkh_pins_t pins,
  input wire logic [7:0] data_lines_in,
  input wire logic power_fail_alarm
);

  // Elaboration check: the counter must hold the longest timed phase
  if (CNT_W < 2 || (1 << CNT_W) <= ACCESS_CYC + SYNC_STAGES
      || (1 << CNT_W) <= RECOVER_CYC || (1 << CNT_W) <= WPULSE_CYC)
  begin : g_cnt_check
    $error("CNT_W too small for the access timing");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_READ, ST_WPULSE, ST_WEND,
    ST_RECOVER} tkh_state_t;

  tkh_state_t state;
  logic [CNT_W-1:0] cnt;
  logic [12:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic is_write;
  logic busy;
  logic done;
  logic err;
  logic clock_hit;
  logic [7:0] dq_s1;
  logic [7:0] dq_s2;
  logic pf_s1;
  logic pf_s2;
  logic setup_phase;
  logic wr_access;
  logic mapped;
  logic start_req;
  logic finish;
  logic abort;

  assign setup_phase = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign mapped = (paddr == REG_CMD) || (paddr == REG_ADDR) || (paddr == REG_WDATA)
    || (paddr == REG_RDATA) || (paddr == REG_STATUS);
  assign start_req = wr_access & (paddr == REG_CMD) & pwdata[CMD_START_BIT];
  assign busy = (state != ST_IDLE);
  assign finish = clk_en & (((state == ST_READ) && (cnt == '0))
    || ((state == ST_WEND)));
  assign abort = pf_s2 & is_write & ((state == ST_SETUP) || (state == ST_WPULSE));

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // Zero wait states: access phase always completes
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;

  // Read data captured in the setup cycle, stable through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (clk_en && setup_phase)
    begin
      unique case (paddr)
        REG_CMD: prdata <= {31'h00000000, is_write} << CMD_WRITE_BIT;
        REG_ADDR: prdata <= {19'h00000, addr_reg};
        REG_WDATA: prdata <= {24'h000000, wdata_reg};
        REG_RDATA: prdata <= {24'h000000, rdata_reg};
        REG_STATUS: prdata <= {27'h0000000, clock_hit, pf_s2, err, done, busy};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Software-written registers
  // ----------------------------------------------------------------
  // Address, data and direction are frozen while a cycle runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_reg <= 13'h0000;
      wdata_reg <= 8'h00;
      is_write <= 1'b0;
    end
    else if (clk_en && wr_access && !busy)
    begin
      if (paddr == REG_ADDR)
        addr_reg <= pwdata[12:0];
      if (paddr == REG_WDATA)
        wdata_reg <= pwdata[7:0];
      if (paddr == REG_CMD)
        is_write <= pwdata[CMD_WRITE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Two stages for the data lines and the power-fail alarm
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
      pf_s1 <= 1'b0;
      pf_s2 <= 1'b0;
    end
    else if (clk_en)
    begin
      dq_s1 <= data_lines_in;
      dq_s2 <= dq_s1;
      pf_s1 <= power_fail_alarm;
      pf_s2 <= pf_s1;
    end
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  // Sequences one read or write per start command
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_IDLE;
      cnt <= '0;
    end
    else if (clk_en)
    begin
      unique case (state)
        ST_IDLE:
          if (start_req && !(pf_s2 && pwdata[CMD_WRITE_BIT]))
            state <= ST_SETUP;
        ST_SETUP:
          if (abort)
          begin
            state <= ST_RECOVER;
            cnt <= CNT_W'(RECOVER_CYC - 1);
          end
          else if (is_write)
          begin
            state <= ST_WPULSE;
            cnt <= CNT_W'(WPULSE_CYC - 1);
          end
          else
          begin
            state <= ST_READ;
            cnt <= CNT_W'(ACCESS_CYC + SYNC_STAGES - 1);
          end
        ST_READ:
          if (cnt == '0)
          begin
            state <= ST_RECOVER;
            cnt <= CNT_W'(RECOVER_CYC - 1);
          end
          else
            cnt <= cnt - 1'b1;
        ST_WPULSE:
          if (abort || cnt == '0)
            state <= ST_WEND;
          else
            cnt <= cnt - 1'b1;
        ST_WEND:
        begin
          state <= ST_RECOVER;
          cnt <= CNT_W'(RECOVER_CYC - 1);
        end
        ST_RECOVER:
          if (cnt == '0)
            state <= ST_IDLE;
          else
            cnt <= cnt - 1'b1;
      endcase
    end
  end

  // Read data taken from the synchronised lines at the end of the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_reg <= 8'h00;
    else if (clk_en && state == ST_READ && cnt == '0)
      rdata_reg <= dq_s2;
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Done and error are sticky; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done <= 1'b0;
      err <= 1'b0;
      clock_hit <= 1'b0;
    end
    else if (clk_en)
    begin
      if (finish && !(pf_s2 && is_write))
        done <= 1'b1;
      else if (wr_access && paddr == REG_STATUS && pwdata[ST_DONE_BIT])
        done <= 1'b0;
      if (abort || (start_req && !busy && pf_s2 && pwdata[CMD_WRITE_BIT])
          || (start_req && busy))
        err <= 1'b1;
      else if (wr_access && paddr == REG_STATUS && pwdata[ST_ERR_BIT])
        err <= 1'b0;
      if (state == ST_SETUP)
        clock_hit <= (addr_reg >= CLOCK_BASE);
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // All pins registered; address held from setup through recovery
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pins <= PINS_IDLE;
    else if (clk_en)
    begin
      pins <= PINS_IDLE;
      unique case (state)
        ST_IDLE:
          pins.addr <= addr_reg;
        ST_SETUP:
        begin
          pins.addr <= addr_reg;
          if (abort)
            pins.data_oe <= 1'b0;
          else if (is_write)
          begin
            pins.chip_sel_n <= 1'b0;
            pins.write_n <= 1'b0;
            pins.data_out <= wdata_reg;
            pins.data_oe <= 1'b1;
          end
          else
          begin
            pins.chip_sel_n <= 1'b0;
            pins.out_drive_n <= 1'b0;
          end
        end
        ST_READ:
        begin
          pins.addr <= addr_reg;
          if (cnt != '0)
          begin
            pins.chip_sel_n <= 1'b0;
            pins.out_drive_n <= 1'b0;
          end
        end
        ST_WPULSE:
        begin
          pins.addr <= addr_reg;
          pins.data_out <= wdata_reg;
          pins.data_oe <= 1'b1;
          if (!abort && cnt != '0)
          begin
            pins.chip_sel_n <= 1'b0;
            pins.write_n <= 1'b0;
          end
        end
        ST_WEND:
        begin
          pins.addr <= addr_reg;
          pins.data_out <= wdata_reg;
          pins.data_oe <= 1'b1;
        end
        ST_RECOVER:
          pins.addr <= addr_reg;
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== verification/tkh_host_props.sv
// Checker for the host controller pin sequences toward the SRAM.
// Assumes it is bound onto tkh_host and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tkh_host_props
  import tkh_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire tkh_pins_t pins,
  input wire logic power_fail_alarm
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ------------------------------------------------
  // Read and write pin sequences
  // ------------------------------------------------
  sequence read_s;
    (!pins.chip_sel_n && !pins.out_drive_n && pins.write_n)[*3]
      ##1 (pins.chip_sel_n && pins.out_drive_n);
  endsequence
  sequence write_s;
    (!pins.chip_sel_n && pins.data_oe && pins.out_drive_n)
      ##1 (pins.write_n && pins.chip_sel_n && pins.data_oe)
      ##1 (pins.chip_sel_n && pins.data_oe) ##1 !pins.data_oe;
  endsequence
  read_walk_a: assert property ($fell(pins.out_drive_n) |-> read_s)
    else $error("read strobes wrong");
  write_walk_a: assert property ($fell(pins.write_n) |-> write_s)
    else $error("write strobes wrong");
  addr_hold_a: assert property ($fell(pins.chip_sel_n) |=> $stable(pins.addr)[*2])
    else $error("address moved in cycle");
  recover_gap_a: assert property ($rose(pins.chip_sel_n) |=> pins.chip_sel_n)
    else $error("no recovery gap");
  data_hold_a: assert property ($rose(pins.write_n) |-> pins.data_oe && $stable(pins.data_out))
    else $error("write data not held");
  no_fight_a: assert property ((pins.data_oe || !pins.write_n) |-> pins.out_drive_n)
    else $error("output drive low in write");
  strobes_together_a: assert property ($fell(pins.write_n) |-> $fell(pins.chip_sel_n))
    else $error("strobes fell apart");
  pfail_block_a: assert property (power_fail_alarm[*4] |=> pins.write_n)
    else $error("write during power fail");
endmodule
bind tkh_host tkh_host_props i_tkh_host_props (.pclk(pclk), .presetn(presetn),
  .pins(pins), .power_fail_alarm(power_fail_alarm));
`default_nettype wire

// ===== verification/tkh_dev_model.sv
// Behavioural model of the byte-wide clock/calendar SRAM.
// Assumes host pins as a tkh_pins_t; resolves the shared data wire.
`timescale 1ns/1ps
`default_nettype none
module tkh_dev_model
  import tkh_pkg::*;
(
  input wire tkh_pins_t pins,
  input wire logic power_fail_alarm,
  output logic [7:0] data_lines
);
  logic [7:0] mem [0:8191];
  logic [7:0] last = 8'h00;
  logic in_wr = 1'b0;
  logic dev_oe;
  // Memory fill; control byte comes up with freeze and load bits clear
  initial
  begin
    for (int i = 0; i < 8192; i++) mem[i] = 8'h5A ^ i[7:0];
    mem[CLOCK_CTRL_ADDR] = 8'h00;
  end
  // Device drives only when selected, output drive low, strobe high
  assign dev_oe = !pins.chip_sel_n && !pins.out_drive_n && pins.write_n
    && !power_fail_alarm;
  // Wire level; toggled stale value when nobody drives
  always @*
  begin
    if (dev_oe) data_lines = mem[pins.addr];
    else if (pins.data_oe) data_lines = pins.data_out;
    else data_lines = ~last;
  end
  // Remember the last driven level
  always @(data_lines)
  begin
    if (dev_oe || pins.data_oe) last = data_lines;
  end
  // Write cycle spans both strobes low; data stored at its first end edge
  always @(pins.write_n, pins.chip_sel_n)
  begin
    if (!pins.write_n && !pins.chip_sel_n) in_wr = 1'b1;
    else if (in_wr)
    begin
      in_wr = 1'b0;
      if (!power_fail_alarm) mem[pins.addr] = data_lines;
    end
  end
endmodule
`default_nettype wire

// ===== verification/tkh_host_tb.sv
// Self-checking bench for the SRAM host controller over APB.
// Assumes tkh_dev_model on the pins and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tkh_host_tb;
  import tkh_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic power_fail_alarm = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  tkh_pins_t pins;
  logic [7:0] data_lines;
  logic [32:0] exp_q[$];
  int n_errors = 0;
  int checks_done = 0;
  // Clock
  always #50 pclk = ~pclk;
  tkh_host #(.CNT_W(4)) i_tkh_host (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .data_lines_in(data_lines), .power_fail_alarm(power_fail_alarm));
  tkh_dev_model i_tkh_dev_model (.pins(pins), .power_fail_alarm(power_fail_alarm),
    .data_lines(data_lines));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Setup, then access held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    exp_q.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask
  // One device access: address, data, start, then the documented walk
  task automatic op(input logic w, input logic [12:0] a, input logic [7:0] d);
    apb(1'b1, REG_ADDR, {19'h0, a});
    apb(1'b1, REG_WDATA, {24'h0, d});
    apb(1'b1, REG_CMD, {30'h0, w, 1'b1});
    repeat (6) @(posedge pclk);
  endtask
  // Monitor takes the oldest note at each completed read
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata}, exp_q.pop_front());
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_sim();
  end
  // Main sequence
  initial
  begin
    logic [12:0] a;
    logic [7:0] d;
    int seed;
    seed = $urandom(32'hA6CA);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(REG_STATUS, 33'h0);
    rd(8'h14, {1'b1, 32'h0});
    $display("test registers done");
    for (int i = 0; i < 12; i++)
    begin
      a = (i < 8) ? CLOCK_BASE + 13'(i) : 13'($urandom_range(8183, 0));
      d = 8'($urandom());
      op(1'b1, a, d);
      op(1'b0, a, 8'h00);
      rd(REG_RDATA, {25'h0, d});
      rd(REG_STATUS, {28'h0, a >= CLOCK_BASE, 4'h2});
      apb(1'b1, REG_STATUS, 32'h6);
    end
    $display("test traffic done");
    power_fail_alarm <= 1'b1;
    repeat (4) @(posedge pclk);
    op(1'b1, a, ~d);
    rd(REG_STATUS, {28'h0, 1'b0, 4'hC});
    power_fail_alarm <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, REG_STATUS, 32'h6);
    op(1'b0, a, 8'h00);
    rd(REG_RDATA, {25'h0, d});
    $display("test power fail done");
    apb(1'b1, REG_CMD, 32'h1);
    // Second start lands while the first read is still running
    apb(1'b1, REG_CMD, 32'h1);
    repeat (6) @(posedge pclk);
    rd(REG_STATUS, {28'h0, 1'b0, 4'h6});
    rd(REG_RDATA, {25'h0, d});
    $display("test busy start done");
    // Writes with the clock enable low must leave the register alone
    clk_en <= 1'b0;
    apb(1'b1, REG_WDATA, 32'h000000A5);
    clk_en <= 1'b1;
    rd(REG_WDATA, 33'h0);
    $display("test clock enable done");
    end_sim();
  end
endmodule
`default_nettype wire
